// [shared/panel_seq_pkg.sv]
// Constants, types and states of the panel power and video sequencer
package panel_seq_pkg;

    // Clock and time base
    localparam int CLK_MHZ          = 200;
    localparam int MS_CYCLES_DFLT   = CLK_MHZ * 1000;

    // Sequencing intervals in milliseconds and the millisecond counter width
    localparam int T3_HPD_MAX_MS    = 200;
    localparam int T7_SINK_MAX_MS   = 50;
    localparam int T8_BL_MIN_MS     = 80;
    localparam int T9_BL_OFF_MIN_MS = 50;
    localparam int T10_OFF_MAX_MS   = 500;
    localparam int T12_HOLD_MIN_MS  = 500;
    localparam int TC_DIM_MIN_MS    = 1;
    localparam int TD_DIM_MIN_MS    = 1;
    localparam int T6_IDLE_DFLT_MS  = 0;
    localparam int MS_W             = 16;

    // Sink register holding the valid video status bit
    localparam logic [19:0] RECEIVE_PORT_STATUS_ADDR = 20'h00205;
    localparam int          SINK_VIDEO_BIT           = 0;

    // APB register map
    localparam logic [7:0] CTRL_OFFS   = 8'h00;
    localparam logic [7:0] STATUS_OFFS = 8'h04;
    localparam logic [7:0] ERR_OFFS    = 8'h08;
    localparam logic [7:0] TIMING_OFFS = 8'h0C;
    localparam int CTRL_PWR_BIT    = 0;
    localparam int CTRL_MODE_LSB   = 1;
    localparam int CTRL_BLKDIS_BIT = 3;
    localparam int TIM_HTOT_LSB    = 16;
    localparam int ERR_HPD_BIT     = 0;
    localparam int ERR_SINK_ON_BIT = 1;
    localparam int ERR_SINK_OFF_BIT = 2;
    localparam int ERR_CFG_BIT     = 3;
    localparam logic [9:0]  V_TOTAL_RST = 10'h320;
    localparam logic [10:0] H_TOTAL_RST = 11'h638;

    // Frame and line limits for every mode
    localparam logic [9:0]  V_ACTIVE  = 10'h300;
    localparam logic [9:0]  V_TOT_MIN = 10'h31C;
    localparam logic [9:0]  V_TOT_MAX = 10'h324;
    localparam logic [10:0] H_ACTIVE  = 11'h556;
    localparam logic [10:0] H_TOT_MIN = 11'h624;
    localparam logic [10:0] H_TOT_MAX = 11'h64C;

    // Nominal pixel clocks in kHz
    localparam logic [16:0] PCLK_60_KHZ = 17'h12A84;
    localparam logic [16:0] PCLK_50_KHZ = 17'h0F8C0;
    localparam logic [16:0] PCLK_48_KHZ = 17'h0EED4;

    typedef enum logic [1:0] {
        MODE_60,
        MODE_50,
        MODE_48,
        MODE_BAD
    } refresh_mode_t;

    typedef enum {
        ST_OFF, ST_SUPPLY_UP, ST_LINK_TRAIN, ST_LINK_IDLE, ST_VIDEO_WAIT,
        ST_BL_POWER, ST_BL_DIM, ST_ON, ST_BL_OFF, ST_LED_DOWN,
        ST_VIDEO_TAIL, ST_SUPPLY_DOWN, ST_OFF_HOLD
    } seq_state_t;

    typedef struct packed {
        logic [16:0] pixel_clock_khz;
        logic [9:0]  frame_line_total;
        logic [9:0]  frame_active_lines;
        logic [9:0]  frame_blank_lines;
        logic [10:0] line_clock_total;
        logic [10:0] line_active_clocks;
        logic [10:0] line_blank_clocks;
    } video_timing_t;

    typedef struct packed {
        logic supply;
        logic link_train_start;
        logic idle_pattern;
        logic valid_video;
        logic led_power;
        logic led_dimming;
        logic led_enable;
    } panel_drive_t;

endpackage

// [tb/panel_power_video_sequencer_tb.sv]
// Self-checking bench for the panel power and video sequencer
`timescale 1ns/1ps
module panel_power_video_sequencer_tb
    import panel_seq_pkg::*;
;
    localparam int MS = 10;
    localparam int SUP = 8, TRN = 7, IDL = 6, VID = 5, PWR = 4;
    localparam int DIM = 3, ENA = 2, HPD = 1, LTR = 0;
    localparam logic [31:0] A_CTRL = 32'(CTRL_OFFS);
    localparam logic [31:0] A_STAT = 32'(STATUS_OFFS);
    localparam logic [31:0] A_ERR  = 32'(ERR_OFFS);
    localparam logic [31:0] A_TIM  = 32'(TIMING_OFFS);
    logic          ref_clk;
    logic          rst;
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [31:0]   paddr;
    logic [31:0]   pwdata;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic          hot_plug_detect;
    logic          link_trained;
    logic [7:0]    receive_port_status;
    panel_drive_t  drive;
    logic          no_video_flag;
    logic          black_video_disable;
    video_timing_t timing;
    video_timing_t et;
    logic [7:0]    hpd_ms;
    logic          sink_mute;
    logic [8:0]    sig;
    logic [8:0]    prev;
    int            t_rise[9];
    int            t_fall[9];
    int            cyc;
    int            mismatches;
    int            samples_checked;
    logic [32:0]   exp_q[$];
    logic [15:0]   rnd;
    logic [9:0]    vt;
    logic [10:0]   ht;
    logic [16:0]   pclk[3] = '{PCLK_60_KHZ, PCLK_50_KHZ, PCLK_48_KHZ};
    logic [31:0]   bad[5][2] = '{'{32'h7, 32'h0638_0320},
        '{32'h1, 32'h0638_031B}, '{32'h1, 32'h0638_0325},
        '{32'h1, 32'h0623_0320}, '{32'h1, 32'h064D_0320}};

    panel_power_video_sequencer #(.MS_CYCLES(MS), .IDLE_MIN_MS(0)) dut (
        .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .hot_plug_detect(hot_plug_detect), .link_trained(link_trained),
        .receive_port_status(receive_port_status), .drive(drive),
        .no_video_flag(no_video_flag),
        .black_video_disable(black_video_disable), .timing(timing));

    panel_sink_model #(.MS_CYCLES(MS)) sink (
        .ref_clk(ref_clk), .rst(rst), .drive(drive), .hpd_ms(hpd_ms),
        .sink_mute(sink_mute), .blk_dis(black_video_disable),
        .hot_plug_detect(hot_plug_detect), .link_trained(link_trained),
        .receive_port_status(receive_port_status), .black_video());

    assign sig = {drive, hot_plug_detect, link_trained};

    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic cmp(input logic [79:0] g, input logic [79:0] e);
        samples_checked++;
        if (g !== e)
        begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic ge(input int a, input int b);
        cmp(80'(a >= b), 80'h1);
    endtask

    task automatic apb(input logic w, input logic [31:0] a,
                       input logic [31:0] d, input logic [32:0] e);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w)
            exp_q.push_back(e);
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1)
            @(posedge ref_clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask

    task automatic rd(input logic [31:0] a, input logic [32:0] e);
        apb(1'b0, a, 32'h0, e);
    endtask

    task automatic wait_sig(input int i, input logic v);
        int n;
        n = 0;
        while (sig[i] !== v && n < 20000)
        begin
            @(posedge ref_clk);
            n++;
        end
        @(posedge ref_clk);
        cmp(80'(sig[i]), 80'(v));
    endtask

    task automatic finish_test;
        $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Read results and the no-video flag compared as they appear
    always @(posedge ref_clk)
    begin
        if (!rst)
            cmp(80'(no_video_flag), 80'(!drive.valid_video));
        if (psel && penable && pready && !pwrite)
            cmp(80'({pslverr, prdata}), 80'(exp_q.pop_front()));
    end

    // Edge times of the panel link
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        prev <= sig;
        for (int i = 0; i < 9; i++)
        begin
            if (sig[i] === 1'b1 && prev[i] === 1'b0)
                t_rise[i] <= cyc;
            if (sig[i] === 1'b0 && prev[i] === 1'b1)
                t_fall[i] <= cyc;
        end
    end

    initial
    begin
        repeat (40000) @(posedge ref_clk);
        mismatches++;
        finish_test;
    end

    initial
    begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        hpd_ms = 8'h03;
        sink_mute = 1'b0;
        mismatches = 0;
        samples_checked = 0;
        cyc = 0;
        prev = 9'h000;
        rnd = 16'hF095;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        rd(A_CTRL, 33'h0);
        rd(A_STAT, 33'h0);
        rd(A_ERR, 33'h0);
        rd(A_TIM, 33'h0_0638_0320);
        rd(32'h0000_0010, 33'h1_0000_0000);
        // Random legal totals in every mode
        for (int k = 0; k < 6; k++)
        begin
            rnd = lfsr(rnd);
            vt = V_TOT_MIN + 10'(rnd[3:0] % 9);
            ht = H_TOT_MIN + 11'(rnd[15:8] % 41);
            wr(A_TIM, {5'h00, ht, 6'h00, vt});
            wr(A_CTRL, 32'(k % 3) << 1);
            repeat (2) @(posedge ref_clk);
            et = '{pclk[k % 3], vt, V_ACTIVE, vt - V_ACTIVE,
                   ht, H_ACTIVE, ht - H_ACTIVE};
            cmp(80'(timing), 80'(et));
        end
        // Illegal mode and totals one past each bound
        for (int k = 0; k < 5; k++)
        begin
            wr(A_TIM, bad[k][1]);
            wr(A_CTRL, bad[k][0]);
            repeat (4) @(posedge ref_clk);
            rd(A_STAT, 33'h0);
            rd(A_ERR, 33'h8);
            wr(A_CTRL, 32'h0);
            wr(A_ERR, 32'h8);
            rd(A_ERR, 33'h0);
        end
        wr(A_TIM, {5'h00, ht, 6'h00, vt});
        // Clean power-up in the 50Hz mode
        wr(A_CTRL, 32'h3);
        wait_sig(ENA, 1'b1);
        ge(t_rise[TRN], t_rise[HPD]);
        ge(t_rise[VID], t_rise[LTR]);
        ge(t_rise[VID], t_rise[IDL]);
        ge(t_rise[PWR] - t_rise[VID], 80 * MS);
        ge(t_rise[DIM] - t_rise[PWR], MS);
        ge(t_rise[ENA], t_rise[DIM]);
        rd(A_STAT, 33'h0707);
        rd(A_CTRL, 33'h3);
        wr(A_CTRL, 32'h2);
        wait_sig(SUP, 1'b0);
        ge(t_fall[DIM], t_fall[ENA]);
        ge(t_fall[PWR] - t_fall[DIM], MS);
        ge(t_fall[VID] - t_fall[PWR], 50 * MS);
        ge(500 * MS, t_fall[SUP] - t_fall[VID]);
        rd(A_ERR, 33'h0);
        // Late hot-plug and a sink that never reports video
        hpd_ms <= 8'hD2;
        sink_mute <= 1'b1;
        wr(A_CTRL, 32'h3);
        wait_sig(SUP, 1'b1);
        ge(t_rise[SUP] - t_fall[SUP], 500 * MS);
        wait_sig(VID, 1'b1);
        repeat (52 * MS) @(posedge ref_clk);
        rd(A_ERR, 33'h3);
        wr(A_CTRL, 32'h0);
        wait_sig(SUP, 1'b0);
        wr(A_ERR, 32'h3);
        rd(A_ERR, 33'h0);
        wr(A_CTRL, 32'h8);
        repeat (2) @(posedge ref_clk);
        cmp(80'(black_video_disable), 80'h1);
        rd(A_CTRL, 33'h8);
        finish_test;
    end
endmodule

// [tb/panel_sink_model.sv]
// Behavioural panel sink answering the sequencer
`timescale 1ns/1ps
module panel_sink_model
    import panel_seq_pkg::*;
#(
    parameter int MS_CYCLES = 10
)
(
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire panel_drive_t drive,
    input  wire logic [7:0]   hpd_ms,
    input  wire logic         sink_mute,
    input  wire logic         blk_dis,
    output logic              hot_plug_detect,
    output logic              link_trained,
    output logic [7:0]        receive_port_status,
    output logic              black_video
);
    int up_cnt;
    int vid_cnt;

    // Black output until valid video is seen, unless disabled
    assign black_video = drive.supply && !blk_dis &&
                         !receive_port_status[0];

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            up_cnt <= 0;
            vid_cnt <= 0;
            hot_plug_detect <= 1'b0;
            link_trained <= 1'b0;
            receive_port_status <= 8'h00;
        end
        else
        begin
            // Intervals counted on the local clock
            up_cnt <= drive.supply ? up_cnt + 1 : 0;
            vid_cnt <= drive.valid_video ? vid_cnt + 1 : 0;
            // Hot-plug, and AUX ready with it, after a chosen delay
            hot_plug_detect <= drive.supply &&
                (up_cnt >= hpd_ms * MS_CYCLES);
            link_trained <= drive.supply &&
                (link_trained || drive.link_train_start);
            // Status bit set 5 ms into video, cleared when video ends
            receive_port_status[0] <= drive.valid_video && !sink_mute
                && (vid_cnt >= 5 * MS_CYCLES);
        end
    end
endmodule

// [verilog/ms_interval_timer.sv]
// Millisecond interval timer restarted on each sequencer step
`timescale 1ns/1ps
module ms_interval_timer
    import panel_seq_pkg::*;
#(
    parameter int TICK_CYCLES = MS_CYCLES_DFLT
)
(
    input  wire logic            ref_clk,
    input  wire logic            rst,
    input  wire logic            restart,
    output logic [MS_W-1:0]      elapsed_ms
);
    logic [31:0]     tick_reg;
    logic [31:0]     tick_next;
    logic [MS_W-1:0] ms_reg;
    logic [MS_W-1:0] ms_next;

    // Local clock counts every interval
    always_comb
    begin
        tick_next = tick_reg + 32'h1; // [RQ21]
        ms_next   = ms_reg;
        if (restart)
        begin
            tick_next = '0;
            ms_next   = '0;
        end
        else if (tick_reg == 32'(TICK_CYCLES - 1))
        begin
            tick_next = '0;
            if (ms_reg != {MS_W{1'b1}})
                ms_next = ms_reg + 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            tick_reg <= '0;
            ms_reg   <= '0;
        end
        else
        begin
            tick_reg <= tick_next;
            ms_reg   <= ms_next;
        end
    end

    assign elapsed_ms = ms_reg;
endmodule

// [verilog/panel_power_video_sequencer.sv]
// Source side power-on/off and video sequencer for an embedded panel
//
// Behaviour
// [RQ1] 50Hz mode pixel clock 63.36..64 MHz
// [RQ2] 48Hz mode pixel clock 60.83..61.45 MHz
// [RQ3] 768 active lines, total 796..804
// [RQ4] 1366 active clocks, total 1572..1612
// [RQ5] Panel accepts normal and power-saving timing
// [RQ6] Sink shows black within 200 ms
// [RQ7] Sink raises hot-plug within 200 ms
// [RQ8] Link training only after hot-plug high
// [RQ9] Idle pattern before valid video
// [RQ10] Sink status bit set within 50 ms
// [RQ11] Backlight on 80 ms after video
// [RQ12] Backlight off 50 ms before video ends
// [RQ13] Supply off within 500 ms of video end
// [RQ14] Dimming 1 ms after LED power rise
// [RQ15] Dimming off 1 ms before LED power falls
// [RQ16] LED enable not before dimming
// [RQ17] LED enable off not after dimming
// [RQ18] No-video flag turns on black video
// [RQ19] Optional black video disable for debug
// [RQ20] Sink tolerates AUX polling, answers within 200 ms
// [RQ21] Intervals counted on local clock, parameterised
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
module panel_power_video_sequencer
    import panel_seq_pkg::*;
#(
    parameter int MS_CYCLES   = MS_CYCLES_DFLT,
    parameter int IDLE_MIN_MS = T6_IDLE_DFLT_MS
)
(
    input  wire logic    ref_clk,
    input  wire logic    rst,
    input  wire logic    psel,
    input  wire logic    penable,
    input  wire logic    pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]  prdata,
    output logic         pready,
    output logic         pslverr,
    input  wire logic    hot_plug_detect,
    input  wire logic    link_trained,
    input  wire logic [7:0] receive_port_status,
    output panel_drive_t drive,
    output logic         no_video_flag,
    output logic         black_video_disable,
    output video_timing_t timing
);
    seq_state_t      state_reg;
    seq_state_t      state_next;
    panel_drive_t    drive_reg;
    panel_drive_t    drive_next;
    logic [MS_W-1:0] ms;
    logic            restart;
    logic            power_req_reg;
    logic            power_req_next;
    refresh_mode_t   mode_reg;
    refresh_mode_t   mode_next;
    logic            blk_dis_reg;
    logic            blk_dis_next;
    logic [9:0]      vtot_reg;
    logic [9:0]      vtot_next;
    logic [10:0]     htot_reg;
    logic [10:0]     htot_next;
    logic [3:0]      err_reg;
    logic [3:0]      err_next;
    logic [31:0]     prdata_reg;
    logic [31:0]     prdata_next;
    video_timing_t   timing_reg;
    video_timing_t   timing_next;
    logic            sink_ok;
    logic            cfg_ok;
    logic            setup;
    logic            access;
    logic            mapped;

    function automatic logic reached(input logic [MS_W-1:0] v, input int lim);
        return v >= MS_W'(lim);
    endfunction

    function automatic logic [16:0] pclk_khz(input refresh_mode_t m);
        unique case (m)
            MODE_50: return PCLK_50_KHZ; // [RQ1]
            MODE_48: return PCLK_48_KHZ; // [RQ2]
            default: return PCLK_60_KHZ; // [RQ5]
        endcase
    endfunction

    ms_interval_timer #(
        .TICK_CYCLES (MS_CYCLES)
    ) u_timer (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .restart    (restart),
        .elapsed_ms (ms)
    );

    assign sink_ok = receive_port_status[SINK_VIDEO_BIT];
    assign cfg_ok  = (mode_reg != MODE_BAD) &&
                     (vtot_reg >= V_TOT_MIN) && (vtot_reg <= V_TOT_MAX) &&
                     (htot_reg >= H_TOT_MIN) && (htot_reg <= H_TOT_MAX);
    assign restart = (state_next != state_reg); // [RQ21]

    // Sequencer steps
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_OFF:
                if (power_req_reg && cfg_ok)
                    state_next = ST_SUPPLY_UP;
            ST_SUPPLY_UP:
                if (!power_req_reg)
                    state_next = ST_SUPPLY_DOWN;
                else if (hot_plug_detect)
                    state_next = ST_LINK_TRAIN; // [RQ8]
            ST_LINK_TRAIN:
                if (!power_req_reg)
                    state_next = ST_SUPPLY_DOWN;
                else if (link_trained)
                    state_next = ST_LINK_IDLE;
            ST_LINK_IDLE:
                if (!power_req_reg)
                    state_next = ST_SUPPLY_DOWN;
                else if (reached(ms, IDLE_MIN_MS))
                    state_next = ST_VIDEO_WAIT; // [RQ9]
            ST_VIDEO_WAIT:
                if (!power_req_reg)
                    state_next = ST_VIDEO_TAIL;
                else if (reached(ms, T8_BL_MIN_MS))
                    state_next = ST_BL_POWER; // [RQ11]
            ST_BL_POWER:
                if (reached(ms, TC_DIM_MIN_MS))
                    state_next = ST_BL_DIM; // [RQ14]
            ST_BL_DIM:
                state_next = ST_ON; // [RQ16]
            ST_ON:
                if (!power_req_reg)
                    state_next = ST_BL_OFF;
            ST_BL_OFF:
                state_next = ST_LED_DOWN; // [RQ17]
            ST_LED_DOWN:
                if (reached(ms, TD_DIM_MIN_MS))
                    state_next = ST_VIDEO_TAIL; // [RQ15]
            ST_VIDEO_TAIL:
                if (reached(ms, T9_BL_OFF_MIN_MS))
                    state_next = ST_SUPPLY_DOWN; // [RQ12]
            ST_SUPPLY_DOWN:
                state_next = ST_OFF_HOLD; // [RQ13]
            ST_OFF_HOLD:
                if (reached(ms, T12_HOLD_MIN_MS))
                    state_next = ST_OFF;
        endcase
    end

    // Pin levels for the step being entered
    always_comb
    begin
        drive_next = '0;
        drive_next.supply = !(state_next inside {ST_OFF, ST_OFF_HOLD});
        drive_next.link_train_start = (state_next == ST_LINK_TRAIN) &&
                                      (state_reg != ST_LINK_TRAIN);
        drive_next.idle_pattern = (state_next == ST_LINK_IDLE); // [RQ9]
        drive_next.valid_video = state_next inside {ST_VIDEO_WAIT,
            ST_BL_POWER, ST_BL_DIM, ST_ON, ST_BL_OFF, ST_LED_DOWN,
            ST_VIDEO_TAIL};
        drive_next.led_power = state_next inside {ST_BL_POWER, ST_BL_DIM,
            ST_ON, ST_BL_OFF, ST_LED_DOWN};
        drive_next.led_dimming = state_next inside {ST_BL_DIM, ST_ON,
            ST_BL_OFF};
        drive_next.led_enable = (state_next == ST_ON);
    end

    // Timing presented to the video path
    always_comb
    begin
        timing_next.pixel_clock_khz    = pclk_khz(mode_reg);
        timing_next.frame_line_total   = vtot_reg; // [RQ3]
        timing_next.frame_active_lines = V_ACTIVE;
        timing_next.frame_blank_lines  = vtot_reg - V_ACTIVE;
        timing_next.line_clock_total   = htot_reg; // [RQ4]
        timing_next.line_active_clocks = H_ACTIVE;
        timing_next.line_blank_clocks  = htot_reg - H_ACTIVE;
    end

    // APB slave, zero wait states
    assign setup  = psel && !penable;
    assign access = psel && penable;
    assign mapped = (paddr[31:8] == '0) && (paddr[1:0] == 2'h0) &&
                    (paddr[7:0] <= TIMING_OFFS);
    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    always_comb
    begin
        power_req_next = power_req_reg;
        mode_next      = mode_reg;
        blk_dis_next   = blk_dis_reg;
        vtot_next      = vtot_reg;
        htot_next      = htot_reg;
        err_next       = err_reg;
        prdata_next    = prdata_reg;
        if (setup && !pwrite)
        begin
            unique case (paddr[7:0])
                CTRL_OFFS:
                    prdata_next = {28'h0, blk_dis_reg, mode_reg,
                                   power_req_reg};
                STATUS_OFFS:
                    prdata_next = {16'h0, 8'(state_reg), 5'h0, sink_ok,
                                   hot_plug_detect, drive_reg.supply};
                ERR_OFFS:
                    prdata_next = {28'h0, err_reg};
                TIMING_OFFS:
                    prdata_next = {5'h0, htot_reg, 6'h0, vtot_reg};
                default:
                    prdata_next = '0;
            endcase
        end
        if (access && pwrite && mapped)
        begin
            unique case (paddr[7:0])
                CTRL_OFFS:
                begin
                    power_req_next = pwdata[CTRL_PWR_BIT];
                    mode_next = refresh_mode_t'(pwdata[CTRL_MODE_LSB +: 2]);
                    blk_dis_next = pwdata[CTRL_BLKDIS_BIT]; // [RQ19]
                end
                ERR_OFFS:
                    err_next = err_reg & ~pwdata[3:0];
                TIMING_OFFS:
                begin
                    vtot_next = pwdata[9:0];
                    htot_next = pwdata[TIM_HTOT_LSB +: 11];
                end
                default:
                    err_next = err_reg;
            endcase
        end
        // Sticky errors, a new event wins over the clear
        if (state_reg == ST_SUPPLY_UP && !hot_plug_detect &&
            reached(ms, T3_HPD_MAX_MS))
            err_next[ERR_HPD_BIT] = 1'b1; // [RQ7] [RQ20]
        if (state_reg == ST_VIDEO_WAIT && !sink_ok &&
            reached(ms, T7_SINK_MAX_MS))
            err_next[ERR_SINK_ON_BIT] = 1'b1; // [RQ10]
        // Sink gets the same allowance to clear as to set its status
        if (state_reg == ST_OFF_HOLD && sink_ok &&
            reached(ms, T7_SINK_MAX_MS))
            err_next[ERR_SINK_OFF_BIT] = 1'b1; // [RQ12]
        if (state_reg == ST_OFF && power_req_reg && !cfg_ok)
            err_next[ERR_CFG_BIT] = 1'b1; // [RQ3]
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg     <= ST_OFF;
            drive_reg     <= '0;
            power_req_reg <= 1'b0;
            mode_reg      <= MODE_60;
            blk_dis_reg   <= 1'b0;
            vtot_reg      <= V_TOTAL_RST;
            htot_reg      <= H_TOTAL_RST;
            err_reg       <= '0;
            prdata_reg    <= '0;
            timing_reg    <= '0;
        end
        else
        begin
            state_reg     <= state_next;
            drive_reg     <= drive_next;
            power_req_reg <= power_req_next;
            mode_reg      <= mode_next;
            blk_dis_reg   <= blk_dis_next;
            vtot_reg      <= vtot_next;
            htot_reg      <= htot_next;
            err_reg       <= err_next;
            prdata_reg    <= prdata_next;
            timing_reg    <= timing_next;
        end
    end

    assign drive               = drive_reg;
    assign prdata              = prdata_reg;
    assign timing              = timing_reg;
    assign no_video_flag       = !drive_reg.valid_video; // [RQ18]
    assign black_video_disable = blk_dis_reg;

    // Cycle counters watched by the checks below
    logic [31:0] vid_on_cnt;
    logic [31:0] led_on_cnt;
    logic [31:0] dim_off_cnt;
    logic [31:0] led_off_cnt;
    logic [31:0] tail_cnt;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            vid_on_cnt  <= '0;
            led_on_cnt  <= '0;
            dim_off_cnt <= '0;
            led_off_cnt <= '0;
            tail_cnt    <= '0;
        end
        else
        begin
            vid_on_cnt  <= drive_reg.valid_video ? vid_on_cnt + 32'h1 : '0;
            led_on_cnt  <= drive_reg.led_power ? led_on_cnt + 32'h1 : '0;
            dim_off_cnt <= drive_reg.led_dimming ? '0 : dim_off_cnt + 32'h1;
            led_off_cnt <= drive_reg.led_power ? '0 : led_off_cnt + 32'h1;
            tail_cnt    <= (drive_reg.supply && !drive_reg.valid_video &&
                            state_reg == ST_SUPPLY_DOWN) ?
                           tail_cnt + 32'h1 : '0;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    AST_TRAIN_AFTER_HPD: assert property ( // [RQ8]
        $rose(drive.link_train_start) |-> $past(hot_plug_detect))
        else $error("link training started without hot-plug");
    AST_IDLE_BEFORE_VIDEO: assert property ( // [RQ9]
        $rose(drive.valid_video) && $past(state_reg) == ST_LINK_IDLE
        |-> $past(drive.idle_pattern))
        else $error("valid video without idle pattern");
    AST_BL_AFTER_VIDEO: assert property ( // [RQ11]
        $rose(drive.led_power) |->
        vid_on_cnt >= 32'(T8_BL_MIN_MS * MS_CYCLES))
        else $error("backlight on too early");
    AST_VIDEO_END: assert property ( // [RQ12]
        $fell(drive.valid_video) && $past(state_reg) == ST_VIDEO_TAIL |->
        led_off_cnt >= 32'(T9_BL_OFF_MIN_MS * MS_CYCLES))
        else $error("video ended too soon after backlight off");
    AST_SUPPLY_OFF: assert property ( // [RQ13]
        tail_cnt <= 32'(T10_OFF_MAX_MS * MS_CYCLES))
        else $error("supply held too long after video end");
    AST_DIM_DELAY: assert property ( // [RQ14]
        $rose(drive.led_dimming) |->
        led_on_cnt >= 32'(TC_DIM_MIN_MS * MS_CYCLES))
        else $error("dimming applied too early");
    AST_DIM_LEAD: assert property ( // [RQ15]
        $fell(drive.led_power) |->
        dim_off_cnt >= 32'(TD_DIM_MIN_MS * MS_CYCLES))
        else $error("led power fell too soon after dimming");
    AST_EN_AFTER_DIM: assert property ( // [RQ16]
        drive.led_enable |-> drive.led_dimming ##1
        (drive.led_dimming || !drive.led_enable))
        else $error("led enable without dimming");
    AST_EN_OFF_FIRST: assert property ( // [RQ17]
        $fell(drive.led_dimming) |->
        !drive.led_enable && !$past(drive.led_enable))
        else $error("led enable still on as dimming fell");
    AST_NO_VIDEO_FLAG: assert property ( // [RQ18]
        $fell(drive.valid_video) |-> no_video_flag [*2])
        else $error("no-video flag missing");
endmodule
